// file: hcdd_addr_decode.v
/*
 * Registered address decode for the alternate optical-drive and modem
 * selects, peripheral port address bits and host data float controls.
 * Assumes host address, read strobe and bases are on the device clock.
 */
`timescale 1ns/1ps
`default_nettype none

module hcdd_addr_decode
(
    input  wire        mclk,                  // device clock
    input  wire        rst_n,                 // synchronous reset, active low
    input  wire        ce,                    // clock enable
    input  wire [15:0] host_addr,             // host address
    input  wire        host_read,             // host read strobe
    input  wire [15:0] alt_optical_base,      // optical drive base
    input  wire [15:0] modem_base,            // modem base
    input  wire        synth_port_hit,        // external synth port access
    input  wire [2:0]  alt_optical_mask,      // optical span mask
    input  wire [7:0]  modem_mask,            // modem span mask
    input  wire        alt_optical_bit7_float,// float bit 7 at base+1
    input  wire        periph_read_float,     // float all on port reads
    input  wire        port_eight,            // eight-location port
    input  wire        ctl0_value,            // control output level
    output reg         alt_optical_select_n,  // optical select, low active
    output reg         modem_select_n,        // modem select, low active
    output reg  [1:0]  periph_addr,           // port address bits 1:0
    output reg         ctl_or_addr2_pin,      // control or address bit 2
    output reg         host_data_bit7_float,  // release host data bit 7
    output reg         host_data_low_float    // release host data bits 6:0
);

    // address inside base..base+span where mask marks the don't-care bits
    function span_hit;
        input [15:0] addr;
        input [15:0] base;
        input [7:0]  mask;
        reg   [15:0] m;
        begin
            m = {8'h00, mask};
            span_hit = ((addr & ~m) == (base & ~m));
        end
    endfunction

    wire opt_hit   = span_hit(host_addr, alt_optical_base, {5'h00, alt_optical_mask});
    wire modem_hit = span_hit(host_addr, modem_base, modem_mask);
    wire port_hit  = opt_hit | modem_hit | synth_port_hit;
    wire opt_plus1 = (host_addr == (alt_optical_base + 16'h0001));

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            alt_optical_select_n <= 1'b1;
            modem_select_n       <= 1'b1;
            periph_addr          <= 2'h0;
            ctl_or_addr2_pin     <= 1'b0;
            host_data_bit7_float <= 1'b0;
            host_data_low_float  <= 1'b0;
        end
        else if (ce)
        begin
            alt_optical_select_n <= ~opt_hit;
            modem_select_n       <= ~modem_hit;
            periph_addr          <= host_addr[1:0];
            ctl_or_addr2_pin     <= port_eight ? host_addr[2] : ctl0_value;
            host_data_bit7_float <= host_read & ((periph_read_float & port_hit)
                                    | (alt_optical_bit7_float & opt_plus1));
            host_data_low_float  <= host_read & periph_read_float & port_hit;
        end
    end

endmodule

`default_nettype wire

// file: hcdd_cfg_source.sv
/* configuration byte source standing in for the eeprom or host loader
   assumes the bench calls send at a falling edge of mclk */
`timescale 1ns/1ps
`default_nettype none
module hcdd_cfg_source #(parameter [7:0] CODE_BASE_ID = 8'h5c) ( // arbitrary value
    input  wire logic       mclk,            // device clock
    output var  logic       load_start,      // load begin pulse
    output var  logic       load_src_eeprom, // 1 eeprom, 0 host
    output var  logic       cfg_byte_valid,  // byte strobe
    output var  logic [7:0] cfg_byte         // byte value
);
    logic [7:0]   mem [1:23];
    logic [183:0] dflt;
    initial
    begin
        dflt = {64'h55bb00dd00038000, CODE_BASE_ID, 112'h20040810800000004875b9fc1003};
        for (int k = 1; k <= 23; k++) mem[k] = dflt[8*(23-k) +: 8];
        {load_start, load_src_eeprom, cfg_byte_valid, cfg_byte} = 11'h000;
    end
    task automatic send(input logic ee);
        begin
            load_start = 1'b1;
            load_src_eeprom = ee;
            @(negedge mclk);
            load_start = 1'b0;
            for (int k = ee ? 1 : 5; k <= 23; k++)
            begin
                cfg_byte_valid = 1'b1;
                cfg_byte = mem[k];
                @(negedge mclk);
                if ($urandom % 2)
                begin
                    // stall: the line carries junk meanwhile
                    cfg_byte_valid = 1'b0;
                    cfg_byte = ~cfg_byte;
                    @(negedge mclk);
                end
            end
            cfg_byte_valid = 1'b0;
            cfg_byte = ~cfg_byte;
        end
    endtask
endmodule
`default_nettype wire

// file: hcdd_chk_monitor.sv
/* port assertions for hcdd_top: key gating, data release, modem decode
   assumes ce is held high and rst_n is the only reset */
`timescale 1ns/1ps
`default_nettype none
module hcdd_chk (
    input wire logic        mclk,                  // clock
    input wire logic        rst_n,                 // reset
    input wire logic [15:0] host_addr,             // address
    input wire logic        host_read,             // read
    input wire logic [15:0] modem_base,            // base
    input wire logic [7:0]  modem_mask,            // span
    input wire logic        modem_select_n,        // select
    input wire logic        wavetable_port_enable, // force
    input wire logic        vendor_key_seen,       // key in
    input wire logic        vendor_key_block,      // block
    input wire logic        vendor_key_accept,     // key out
    input wire logic        pnp_key_seen,          // key in
    input wire logic        pnp_key_block,         // block
    input wire logic        pnp_key_accept,        // key out
    input wire logic [1:0]  periph_addr,           // port addr
    input wire logic        host_data_bit7_float,  // bit 7
    input wire logic        host_data_low_float    // bits 6:0
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_full_read;
        host_read && wavetable_port_enable ##1 !modem_select_n;
    endsequence
    a_vkey_blocked: assert property (vendor_key_seen && vendor_key_block |=> !vendor_key_accept)
        else $error("vendor key passed while blocked");
    a_vkey_passed: assert property (vendor_key_seen && !vendor_key_block |=> vendor_key_accept)
        else $error("vendor key lost");
    a_vkey_cause: assert property (vendor_key_accept |-> $past(vendor_key_seen))
        else $error("vendor key accept without key");
    a_pkey_follow: assert property ($past(rst_n) |-> pnp_key_accept ==
        ($past(pnp_key_seen) && !$past(pnp_key_block))) else $error("pnp key gating wrong");
    a_float_quiet: assert property (!$past(host_read) |->
        !host_data_bit7_float && !host_data_low_float) else $error("data released without read");
    a_float_forced: assert property (s_full_read |-> host_data_low_float && host_data_bit7_float)
        else $error("port read not released");
    a_modem_span: assert property ($past(rst_n) |-> modem_select_n ==
        !$past(((host_addr ^ modem_base) & ~{8'h00, modem_mask}) == 16'h0000))
        else $error("modem select wrong");
    a_port_addr: assert property ($past(rst_n) |-> periph_addr == $past(host_addr[1:0]))
        else $error("port address wrong");
endmodule
bind hcdd_top hcdd_chk u_chk (.*);
`default_nettype wire

// file: hcdd_defines.vh
/*
 * Byte indices, default values, field positions and fixed patterns for the
 * hardware configuration decoder.
 * Assumes it is included by its bare name from each design file that needs it.
 */
`ifndef HCDD_DEFINES_VH
`define HCDD_DEFINES_VH

// byte indices within the configuration block (eeprom numbering)
`define HCDD_IDX_VALID1      5'h01
`define HCDD_IDX_VALID2      5'h02
`define HCDD_IDX_LEN_HI      5'h03
`define HCDD_IDX_LEN_LO      5'h04
`define HCDD_IDX_OPT_MASK    5'h05
`define HCDD_IDX_MODEM_MASK  5'h06
`define HCDD_IDX_MISC        5'h07
`define HCDD_IDX_CODE_BASE   5'h09
`define HCDD_IDX_PORT_SIZE   5'h11
`define HCDD_IDX_IRQ_AB      5'h13
`define HCDD_IDX_IRQ_CD      5'h14
`define HCDD_IDX_IRQ_EF      5'h15
`define HCDD_IDX_DMA_AB      5'h16
`define HCDD_IDX_DMA_C       5'h17
`define HCDD_IDX_LAST        5'h17
`define HCDD_IDX_HOST_FIRST  5'h05

// block lengths
`define HCDD_EE_LEN          5'h17
`define HCDD_HOST_LEN        5'h13

// fixed patterns
`define HCDD_VALID1_PAT      8'h55
`define HCDD_VALID2_PAT      8'hbb
`define HCDD_PORT_SIZE_8     8'h08

// reset values
`define HCDD_RST_LEN_HI      8'h00
`define HCDD_RST_LEN_LO      8'hdd
`define HCDD_RST_OPT_MASK    8'h00
`define HCDD_RST_MODEM_MASK  8'h03
`define HCDD_RST_MISC        8'h80
`define HCDD_RST_GLOBAL      8'h00
`define HCDD_RST_CODE_BASE   8'h00
`define HCDD_RST_B10         8'h20
`define HCDD_RST_B11         8'h04
`define HCDD_RST_B12         8'h08
`define HCDD_RST_B13         8'h10
`define HCDD_RST_B14         8'h80
`define HCDD_RST_B15         8'h00
`define HCDD_RST_B16         8'h00
`define HCDD_RST_PORT_SIZE   8'h00
`define HCDD_RST_B18         8'h48
`define HCDD_RST_IRQ_AB      8'h75
`define HCDD_RST_IRQ_CD      8'hb9
`define HCDD_RST_IRQ_EF      8'hfc
`define HCDD_RST_DMA_AB      8'h10
`define HCDD_RST_DMA_C       8'h03

// misc configuration byte field positions
`define HCDD_MISC_OPT_B7F    0
`define HCDD_MISC_RD_FLOAT   1
`define HCDD_MISC_VOL_EN     2
`define HCDD_MISC_MODEM_HI   3
`define HCDD_MISC_VKEY_BLK   4
`define HCDD_MISC_PKEY_BLK   5
`define HCDD_MISC_SYNTH_HI   6
`define HCDD_MISC_OPT_HI     7

`endif

// file: hcdd_sync.v
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes the inputs are asynchronous levels; only the second stage is read.
 */
`timescale 1ns/1ps
`default_nettype none

module hcdd_sync
#(
    parameter W = 6
)
(
    input  wire         mclk,     // device clock
    input  wire         rst_n,    // synchronous reset, active low
    input  wire         ce,       // clock enable
    input  wire [W-1:0] din,      // asynchronous levels
    output wire [W-1:0] dout      // synchronised levels
);

    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end
        else if (ce)
        begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;

endmodule

`default_nettype wire

// file: hcdd_top.v
/*
 * Hardware configuration data decoder: collects the configuration block
 * from the eeprom or a host download, validates the eeprom header, holds the applied
 * bytes and drives the decoded controls, routing numbers and selects.
 * Assumes bytes, commands, address and key detects come from logic on mclk;
 * interrupt and volume pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hcdd_defines.vh"

module hcdd_top
#(
    parameter [7:0] CODE_BASE_ID = 8'h5c   // arbitrary value
)
(
    input  wire        mclk,                  // device clock, 125 MHz
    input  wire        rst_n,                 // synchronous reset, active low
    input  wire        ce,                    // clock enable
    input  wire        load_start,            // pulse: begin a load
    input  wire        load_src_eeprom,       // 1 eeprom, 0 host, with start
    input  wire        cfg_byte_valid,        // pulse: cfg_byte valid
    input  wire [7:0]  cfg_byte,              // configuration byte
    input  wire        apply_cmd,             // pulse: host apply command
    input  wire [15:0] host_addr,             // host address
    input  wire        host_read,             // host read strobe
    input  wire [15:0] alt_optical_base,      // optical drive base
    input  wire [15:0] modem_base,            // modem base
    input  wire        synth_port_hit,        // external synth port access
    input  wire        ctl0_value,            // control output level
    input  wire        wavetable_port_enable, // wavetable port on
    input  wire        serial_port_switch,    // serial port switched
    input  wire        modem_irq_in,          // modem interrupt pin
    input  wire        synth_irq_in,          // synth interrupt pin
    input  wire        optical_irq_in,        // optical interrupt pin
    input  wire        vol_up_in,             // volume up pin
    input  wire        vol_down_in,           // volume down pin
    input  wire        vol_mute_in,           // volume mute pin
    input  wire        vendor_key_seen,       // pulse: vendor key matched
    input  wire        pnp_key_seen,          // pulse: pnp key matched
    output reg         load_busy,             // load in progress
    output reg         host_apply_pending,    // host bytes await apply
    output reg         eeprom_present,        // eeprom validated
    output reg         load_error,            // bad validation or apply while idle
    output reg         code_base_ok,          // code base matched at apply
    output reg  [15:0] resource_length,       // remaining resource length
    output reg         modem_irq_active,      // modem interrupt asserted
    output reg         synth_irq_active,      // synth interrupt asserted
    output reg         optical_irq_active,    // optical interrupt asserted
    output reg         vol_up,                // volume up request
    output reg         vol_down,              // volume down request
    output reg         vol_mute,              // volume mute request
    output reg         vendor_key_accept,     // pulse: vendor key honoured
    output reg         pnp_key_accept,        // pulse: pnp key honoured
    output wire        alt_optical_select_n,  // optical select, low active
    output wire        modem_select_n,        // modem select, low active
    output wire [1:0]  periph_addr,           // port address bits 1:0
    output wire        ctl_or_addr2_pin,      // control or address bit 2
    output wire        host_data_bit7_float,  // release host data bit 7
    output wire        host_data_low_float,   // release host data bits 6:0
    output wire [23:0] irq_pins_a_to_f,       // interrupt numbers, a low
    output wire [11:0] dma_pins_a_to_c,       // dma channels, a low
    output wire [2:0]  alt_optical_mask,      // applied optical mask
    output wire [7:0]  modem_mask,            // applied modem mask
    output wire        hw_volume_enable,      // applied volume enable
    output wire        vendor_key_block,      // applied vendor key block
    output wire        pnp_key_block          // applied pnp key block
);

    localparam [3:0] ST_IDLE  = 4'h1;
    localparam [3:0] ST_LOAD  = 4'h2;
    localparam [3:0] ST_WAIT  = 4'h4;
    localparam [3:0] ST_APPLY = 4'h8;

    // default for each applied byte index
    function [7:0] byte_default;
        input [4:0] idx;
        begin
            case (idx)
                5'h05:   byte_default = `HCDD_RST_OPT_MASK;
                5'h06:   byte_default = `HCDD_RST_MODEM_MASK;
                5'h07:   byte_default = `HCDD_RST_MISC;
                5'h08:   byte_default = `HCDD_RST_GLOBAL;
                5'h09:   byte_default = `HCDD_RST_CODE_BASE;
                5'h0a:   byte_default = `HCDD_RST_B10;
                5'h0b:   byte_default = `HCDD_RST_B11;
                5'h0c:   byte_default = `HCDD_RST_B12;
                5'h0d:   byte_default = `HCDD_RST_B13;
                5'h0e:   byte_default = `HCDD_RST_B14;
                5'h0f:   byte_default = `HCDD_RST_B15;
                5'h10:   byte_default = `HCDD_RST_B16;
                5'h11:   byte_default = `HCDD_RST_PORT_SIZE;
                5'h12:   byte_default = `HCDD_RST_B18;
                5'h13:   byte_default = `HCDD_RST_IRQ_AB;
                5'h14:   byte_default = `HCDD_RST_IRQ_CD;
                5'h15:   byte_default = `HCDD_RST_IRQ_EF;
                5'h16:   byte_default = `HCDD_RST_DMA_AB;
                5'h17:   byte_default = `HCDD_RST_DMA_C;
                default: byte_default = 8'h00;
            endcase
        end
    endfunction

    reg [7:0]  shadow_mem [1:23];
    reg [7:0]  act_mem    [5:23];
    reg [3:0]  state_ff;
    reg [4:0]  idx_ff;
    reg        src_ee_ff;
    integer    i;

    wire [7:0] misc = act_mem[`HCDD_IDX_MISC];
    wire [5:0] pins_sync;

    // loader: collect bytes, validate header, apply on completion or command
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_ff           <= ST_IDLE;
            idx_ff             <= 5'h00;
            src_ee_ff          <= 1'b0;
            load_busy          <= 1'b0;
            host_apply_pending <= 1'b0;
            eeprom_present     <= 1'b0;
            load_error         <= 1'b0;
            code_base_ok       <= 1'b0;
            resource_length    <= {`HCDD_RST_LEN_HI, `HCDD_RST_LEN_LO};
            for (i = 5; i <= 23; i = i + 1)
                act_mem[i] <= byte_default(i[4:0]);
        end
        else if (ce)
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (load_start)
                    begin
                        src_ee_ff  <= load_src_eeprom;
                        // host form skips the four header bytes
                        idx_ff     <= load_src_eeprom ? `HCDD_IDX_VALID1
                                                      : `HCDD_IDX_HOST_FIRST;
                        load_busy  <= 1'b1;
                        load_error <= apply_cmd;
                        state_ff   <= ST_LOAD;
                    end
                    else if (apply_cmd)
                        load_error <= 1'b1;
                end
                ST_LOAD:
                begin
                    if (cfg_byte_valid)
                    begin
                        shadow_mem[idx_ff] <= cfg_byte;
                        idx_ff <= idx_ff + 5'h01;
                        if (src_ee_ff && idx_ff == `HCDD_IDX_VALID2)
                        begin
                            if (shadow_mem[`HCDD_IDX_VALID1] == `HCDD_VALID1_PAT
                                && cfg_byte == `HCDD_VALID2_PAT)
                                eeprom_present <= 1'b1;
                            else
                            begin
                                eeprom_present <= 1'b0;
                                load_error     <= 1'b1;
                                load_busy      <= 1'b0;
                                state_ff       <= ST_IDLE;
                            end
                        end
                        if (idx_ff == `HCDD_IDX_LAST)
                        begin
                            if (src_ee_ff)
                                state_ff <= ST_APPLY;
                            else
                            begin
                                host_apply_pending <= 1'b1;
                                state_ff           <= ST_WAIT;
                            end
                        end
                    end
                end
                ST_WAIT:
                begin
                    // downloaded bytes take effect only on the apply command
                    if (apply_cmd)
                        state_ff <= ST_APPLY;
                    else if (load_start)
                    begin
                        host_apply_pending <= 1'b0;
                        state_ff           <= ST_IDLE;
                    end
                end
                ST_APPLY:
                begin
                    for (i = 5; i <= 23; i = i + 1)
                        act_mem[i] <= shadow_mem[i];
                    if (src_ee_ff)
                        resource_length <= {shadow_mem[`HCDD_IDX_LEN_HI],
                                            shadow_mem[`HCDD_IDX_LEN_LO]};
                    code_base_ok <= (shadow_mem[`HCDD_IDX_CODE_BASE] == CODE_BASE_ID);
                    host_apply_pending <= 1'b0;
                    load_busy          <= 1'b0;
                    state_ff           <= ST_IDLE;
                end
                default:
                begin
                    load_busy <= 1'b0;
                    state_ff  <= ST_IDLE;
                end
            endcase
        end
    end

    hcdd_sync #(.W(6)) u_pin_sync
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .din   ({vol_mute_in, vol_down_in, vol_up_in,
                 optical_irq_in, synth_irq_in, modem_irq_in}),
        .dout  (pins_sync)
    );

    // polarity-normalised interrupts, gated volume pins and key filtering
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            modem_irq_active   <= 1'b0;
            synth_irq_active   <= 1'b0;
            optical_irq_active <= 1'b0;
            vol_up             <= 1'b0;
            vol_down           <= 1'b0;
            vol_mute           <= 1'b0;
            vendor_key_accept  <= 1'b0;
            pnp_key_accept     <= 1'b0;
        end
        else if (ce)
        begin
            modem_irq_active   <= ~(pins_sync[0] ^ misc[`HCDD_MISC_MODEM_HI]);
            synth_irq_active   <= ~(pins_sync[1] ^ misc[`HCDD_MISC_SYNTH_HI]);
            optical_irq_active <= ~(pins_sync[2] ^ misc[`HCDD_MISC_OPT_HI]);
            vol_up             <= pins_sync[3] & misc[`HCDD_MISC_VOL_EN];
            vol_down           <= pins_sync[4] & misc[`HCDD_MISC_VOL_EN];
            vol_mute           <= pins_sync[5] & misc[`HCDD_MISC_VOL_EN];
            vendor_key_accept  <= vendor_key_seen & ~misc[`HCDD_MISC_VKEY_BLK];
            pnp_key_accept     <= pnp_key_seen & ~misc[`HCDD_MISC_PKEY_BLK];
        end
    end

    hcdd_addr_decode u_decode
    (
        .mclk                   (mclk),
        .rst_n                  (rst_n),
        .ce                     (ce),
        .host_addr              (host_addr),
        .host_read              (host_read),
        .alt_optical_base       (alt_optical_base),
        .modem_base             (modem_base),
        .synth_port_hit         (synth_port_hit),
        .alt_optical_mask       (act_mem[`HCDD_IDX_OPT_MASK][2:0]),
        .modem_mask             (act_mem[`HCDD_IDX_MODEM_MASK]),
        .alt_optical_bit7_float (misc[`HCDD_MISC_OPT_B7F]),
        .periph_read_float      (misc[`HCDD_MISC_RD_FLOAT] | wavetable_port_enable
                                 | serial_port_switch),
        .port_eight             (act_mem[`HCDD_IDX_PORT_SIZE] == `HCDD_PORT_SIZE_8),
        .ctl0_value             (ctl0_value),
        .alt_optical_select_n   (alt_optical_select_n),
        .modem_select_n         (modem_select_n),
        .periph_addr            (periph_addr),
        .ctl_or_addr2_pin       (ctl_or_addr2_pin),
        .host_data_bit7_float   (host_data_bit7_float),
        .host_data_low_float    (host_data_low_float)
    );

    // routing nibbles are binary bus numbers, lower nibble first
    assign irq_pins_a_to_f = {act_mem[`HCDD_IDX_IRQ_EF], act_mem[`HCDD_IDX_IRQ_CD],
                              act_mem[`HCDD_IDX_IRQ_AB]};
    // upper nibble of the last dma byte is reserved zero and not routed
    assign dma_pins_a_to_c = {act_mem[`HCDD_IDX_DMA_C][3:0],
                              act_mem[`HCDD_IDX_DMA_AB]};
    assign alt_optical_mask = act_mem[`HCDD_IDX_OPT_MASK][2:0];
    assign modem_mask       = act_mem[`HCDD_IDX_MODEM_MASK];
    assign hw_volume_enable = misc[`HCDD_MISC_VOL_EN];
    assign vendor_key_block = misc[`HCDD_MISC_VKEY_BLK];
    assign pnp_key_block    = misc[`HCDD_MISC_PKEY_BLK];

endmodule

`default_nettype wire

// file: test_hcdd_top.sv
/* self-checking bench for hcdd_top: random loads, decode traffic and pins
   assumes the checker is bound from its own file and ce stays high */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("Error %0t: got %h want %h", $time, g, e); end end
module test_hcdd_top;
    wire        load_start, load_src_eeprom, cfg_byte_valid, load_busy, host_apply_pending;
    wire        eeprom_present, load_error, code_base_ok, modem_irq_active, synth_irq_active;
    wire        optical_irq_active, vol_up, vol_down, vol_mute, vendor_key_accept, pnp_key_accept;
    wire        alt_optical_select_n, modem_select_n, ctl_or_addr2_pin, host_data_bit7_float;
    wire        host_data_low_float, hw_volume_enable, vendor_key_block, pnp_key_block;
    wire [7:0]  cfg_byte, modem_mask;
    wire [15:0] resource_length;
    wire [1:0]  periph_addr;
    wire [2:0]  alt_optical_mask;
    wire [11:0] dma_pins_a_to_c;
    wire [23:0] irq_pins_a_to_f;
    logic       mclk = 0, rst_n = 0, ce = 1, apply_cmd = 0, host_read = 0, synth_port_hit = 0;
    logic       ctl0_value = 0, wavetable_port_enable = 0, serial_port_switch = 0;
    logic       modem_irq_in = 0, synth_irq_in = 0, optical_irq_in = 0, vol_up_in = 0;
    logic       vol_down_in = 0, vol_mute_in = 0, vendor_key_seen = 0, pnp_key_seen = 0;
    logic [15:0] host_addr = 0, alt_optical_base = 0, modem_base = 0;
    int         failures = 0, checks_done = 0;
    hcdd_top dut (.*);
    hcdd_cfg_source src (.*);
    always #4 mclk = ~mclk;
    task automatic close_out;
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wait_on(input int sel);
        int n;
        for (n = 0; n < 200 && (sel ? !host_apply_pending : load_busy); n++) @(negedge mclk);
        if (n == 200)
        begin
            failures++;
            $display("Error %0t: wait timed out", $time);
            close_out();
        end
    endtask
    task automatic check_fields;
        `CHK(irq_pins_a_to_f, {src.mem[21], src.mem[20], src.mem[19]})
        `CHK(dma_pins_a_to_c, {src.mem[23][3:0], src.mem[22]})
        `CHK({alt_optical_mask, modem_mask}, {src.mem[5][2:0], src.mem[6]})
        `CHK({pnp_key_block, vendor_key_block, hw_volume_enable},
            {src.mem[7][5:4], src.mem[7][2]})
        `CHK(resource_length, {src.mem[3], src.mem[4]})
    endtask
    task automatic traffic;
        logic [5:0] pin;
        for (int n = 0; n < 64; n++)
        begin
            @(negedge mclk);
            if (n > 0) `CHK(ctl_or_addr2_pin, src.mem[17][3] ? host_addr[2] : ctl0_value)
            if (n > 0) `CHK(alt_optical_select_n,
                ((host_addr ^ alt_optical_base) & ~16'(src.mem[5][2:0])) != 0)
            {host_read, ctl0_value, vendor_key_seen, pnp_key_seen} = $urandom;
            wavetable_port_enable = ($urandom % 3 == 0);
            serial_port_switch = ($urandom % 5 == 0);
            synth_port_hit = ($urandom % 7 == 0);
            host_addr = ($urandom % 2 ? modem_base : alt_optical_base) + 16'($urandom % 10);
            if (n % 4 == 3)
            begin
                `CHK({modem_irq_active, synth_irq_active, optical_irq_active},
                    ~(pin[5:3] ^ {src.mem[7][3], src.mem[7][6], src.mem[7][7]}))
                `CHK({vol_up, vol_down, vol_mute}, pin[2:0] & {3{src.mem[7][2]}})
            end
            if (n % 4 == 0) pin = $urandom;
            {modem_irq_in, synth_irq_in, optical_irq_in, vol_up_in, vol_down_in, vol_mute_in} = pin;
        end
    endtask
    initial
    begin
        void'($urandom(32'h0ad9));
        {alt_optical_base, modem_base} = $urandom;
        repeat (16) @(negedge mclk);
        rst_n = 1;
        @(negedge mclk);
        check_fields();
        traffic();
        for (int t = 0; t < 6; t++)
        begin
            for (int k = t % 2 ? 5 : 3; k <= 22; k++) if (k < 8 || k > 18) src.mem[k] = $urandom;
            src.mem[5] = 8'h07 >> ($urandom % 4);
            src.mem[6] = 8'hff >> ($urandom % 9);
            src.mem[17] = {4'h0, t[1], 3'h0};
            src.mem[23] = $urandom % 16;
            src.send(t % 2 == 0);
            if (t % 2)
            begin
                wait_on(1);
                apply_cmd = 1'b1;
                @(negedge mclk);
                apply_cmd = 1'b0;
            end
            wait_on(0);
            check_fields();
            `CHK({eeprom_present, code_base_ok}, 2'b11)
            traffic();
        end
        src.mem[2] = 8'hbb ^ 8'($urandom % 255 + 1);
        src.mem[19] = ~src.mem[19];
        src.send(1);
        wait_on(0);
        `CHK({load_error, eeprom_present, irq_pins_a_to_f[7:0]}, {2'b10, ~src.mem[19]})
        close_out();
    end
endmodule
`default_nettype wire
